// ---- rtl/fcs_pkg.sv ----
// Shared constants, types and helpers of the framer channel services block
package fcs_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [9:0] IDX_RX_MON_SEL = 10'h012;
  localparam logic [9:0] IDX_RX_MON_DATA = 10'h060;
  localparam logic [9:0] IDX_TX_CTRL3 = 10'h183;
  localparam logic [9:0] IDX_TX_CTRL4 = 10'h186;
  localparam logic [9:0] IDX_TX_MON_SEL = 10'h189;
  localparam logic [9:0] IDX_TX_PAT1 = 10'h1ac;
  localparam logic [9:0] IDX_TX_PAT2 = 10'h1ad;
  localparam logic [9:0] IDX_TX_MON_DATA = 10'h1bb;
  localparam logic [9:0] IDX_TX_IDLE = 10'h200;
  localparam logic [9:0] IDX_RX_IDLE = 10'h220;
  localparam logic [9:0] IDX_TX_IDLE_EN = 10'h240;
  localparam logic [9:0] IDX_RX_IDLE_EN = 10'h244;
  localparam logic [9:0] IDX_LOOPBACK = 10'h248;
  localparam logic [9:0] IDX_TX_CTRL1 = 10'h24c;
  localparam logic [9:0] IDX_MODE = 10'h24d;
  localparam logic [9:0] IDX_SA = 10'h24e;
  // Field positions
  localparam int CTL3_LOOP_BIT = 0;
  localparam int CTL1_CRC_BIT = 0;
  localparam int CTL4_LEN_LSB = 0;
  localparam int MODE_E1_BIT = 0;
  localparam int MODE_NOFBIT_BIT = 1;
  localparam int SA_EN_BIT = 7;
  // Reset value of every control register
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Frame geometry and checksum
  localparam logic [7:0] T1_LAST_BIT = 8'hc0;
  localparam logic [7:0] E1_LAST_BIT = 8'hff;
  localparam logic [3:0] CRC4_POLY = 4'h3;
  localparam logic [2:0] SMF_LAST_FRAME = 3'h7;
  localparam logic [4:0] T1_LAST_CH = 5'h17;

  // Position of one bit inside a frame
  typedef struct packed {
    logic [4:0] ch;
    logic [2:0] bt;
    logic fbit;
  } fcs_pos_t;

  // Bit counter to channel, bit and framing-bit flag
  function automatic fcs_pos_t fcs_pos(input logic [7:0] cnt, input logic e1);
    fcs_pos_t p;
    logic [7:0] c;
    c = e1 ? cnt : cnt - 8'h01;
    p.ch = c[7:3];
    p.bt = c[2:0];
    p.fbit = !e1 && (cnt == 8'h00);
    if (p.fbit)
    begin
      p.ch = 5'h00;
      p.bt = 3'h0;
    end
    return p;
  endfunction

  // Last pattern index for each code length selection: 5, 6, 7 or 16 bits
  function automatic logic [3:0] fcs_code_last(input logic [1:0] sel);
    case (sel)
      2'h0: return 4'h4;
      2'h1: return 4'h5;
      2'h2: return 4'h6;
      default: return 4'hf;
    endcase
  endfunction
endpackage

// ---- rtl/fcs_top.sv ----
// Framer channel services: monitors, idle codes, loopback, checksum update, loop code
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module fcs_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Backplane transmit side
  input wire logic tx_backplane_clock,
  input wire logic tx_frame_sync,
  input wire logic tx_serial_data,
  // Line receive side
  input wire logic rx_backplane_clock,
  input wire logic rx_frame_sync,
  input wire logic rx_line_data,
  // Serial results
  output logic tx_line_data,
  output logic rx_serial_data
);
  // Index 0 is transmit, index 1 is receive
  logic [1:0] ck_m_r, ck_s_r, ck_d_r, sy_m_r, sy_s_r, dt_m_r, dt_s_r;
  logic [1:0] edge_w;
  logic [7:0] tx_idle_r [32];
  logic [7:0] rx_idle_r [32];
  logic [31:0] tx_ie_r, rx_ie_r, lb_r;
  logic [7:0] tx_sel_r, rx_sel_r, ctl1_r, ctl3_r, ctl4_r, pat1_r, pat2_r, mode_r, sa_r;
  logic [7:0] mon_r [2];
  logic [7:0] sh_r [2];
  logic [7:0] cnt_r [2];
  logic [7:0] cur [2];
  logic [4:0] sel [2];
  fcs_pkg::fcs_pos_t pos [2];
  logic [1:0] ob;
  logic [3:0] frm_r, frm;
  logic [3:0] pidx_r, plast;
  logic [15:0] pat_w;
  logic [3:0] acc_r, adj_r, acc_nxt;
  logic e1, recalc, loop_on, nofbit, tx_bit, rx_bit, c_pos, patbit, smf_end;
  logic [9:0] idx;
  logic wr_en;
  logic [7:0] rd_byte;
  logic rd_err;

  // Control decode
  assign e1 = mode_r[fcs_pkg::MODE_E1_BIT];
  assign nofbit = mode_r[fcs_pkg::MODE_NOFBIT_BIT];
  assign recalc = e1 && ctl3_r[fcs_pkg::CTL3_LOOP_BIT] && ctl1_r[fcs_pkg::CTL1_CRC_BIT];
  assign loop_on = !e1 && ctl3_r[fcs_pkg::CTL3_LOOP_BIT];
  assign plast = fcs_pkg::fcs_code_last(ctl4_r[fcs_pkg::CTL4_LEN_LSB +: 2]);
  assign pat_w = {pat1_r, pat2_r};
  assign patbit = pat_w[~pidx_r];
  assign sel[0] = tx_sel_r[4:0];
  assign sel[1] = rx_sel_r[4:0];
  assign ob = {rx_bit, tx_bit};
  assign edge_w = ck_s_r & ~ck_d_r;

  // Two-stage synchronisers for link clocks, syncs and data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ck_m_r <= 2'h0;
      ck_s_r <= 2'h0;
      ck_d_r <= 2'h0;
      sy_m_r <= 2'h0;
      sy_s_r <= 2'h0;
      dt_m_r <= 2'h0;
      dt_s_r <= 2'h0;
    end
    else
    begin
      ck_m_r <= {rx_backplane_clock, tx_backplane_clock};
      ck_s_r <= ck_m_r;
      ck_d_r <= ck_s_r;
      sy_m_r <= {rx_frame_sync, tx_frame_sync};
      sy_s_r <= sy_m_r;
      dt_m_r <= {rx_line_data, tx_serial_data};
      dt_s_r <= dt_m_r;
    end
  end

  // Per-direction bit counter and channel monitor
  for (genvar d = 0; d < 2; d++)
  begin : g_dir
    assign cur[d] = sy_s_r[d] ? 8'h00 : cnt_r[d];
    assign pos[d] = fcs_pkg::fcs_pos(cur[d], e1);
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        cnt_r[d] <= 8'h00;
        sh_r[d] <= 8'h00;
        mon_r[d] <= fcs_pkg::RST_BYTE;
      end
      else if (edge_w[d])
      begin
        if (cur[d] == (e1 ? fcs_pkg::E1_LAST_BIT : fcs_pkg::T1_LAST_BIT))
          cnt_r[d] <= 8'h00;
        else
          cnt_r[d] <= cur[d] + 8'h01;
        sh_r[d] <= {sh_r[d][6:0], ob[d]};
        if (!pos[d].fbit && pos[d].bt == 3'h7 && pos[d].ch == sel[d])
          mon_r[d] <= {sh_r[d][6:0], ob[d]};
      end
    end
  end

  // Frame number inside the multiframe
  assign frm = sy_s_r[0] ? 4'h0 : frm_r;
  assign smf_end = cur[0] == fcs_pkg::E1_LAST_BIT && frm[2:0] == fcs_pkg::SMF_LAST_FRAME;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frm_r <= 4'h0;
    else if (edge_w[0])
      frm_r <= (cur[0] == fcs_pkg::E1_LAST_BIT) ? frm + 4'h1 : frm;
  end

  // Transmit bit selection
  always_comb
  begin
    tx_bit = dt_s_r[0];
    c_pos = 1'b0;
    if (!pos[0].fbit)
    begin
      if (lb_r[pos[0].ch])
        tx_bit = dt_s_r[1];
      if (tx_ie_r[pos[0].ch])
        tx_bit = tx_idle_r[pos[0].ch][~pos[0].bt];
    end
    if (recalc && pos[0].ch == 5'h00)
    begin
      if (!frm[0] && pos[0].bt == 3'h0)
      begin
        c_pos = 1'b1;
        tx_bit = dt_s_r[0] ^ adj_r[~frm[2:1]];
      end
      else if (frm[0] && sa_r[fcs_pkg::SA_EN_BIT] && pos[0].bt >= 3'h3)
        tx_bit = sa_r[~pos[0].bt];
    end
    if (loop_on && !(pos[0].fbit && !nofbit))
      tx_bit = patbit;
  end

  // Receive bit selection
  always_comb
  begin
    rx_bit = dt_s_r[1];
    if (!pos[1].fbit && rx_ie_r[pos[1].ch])
      rx_bit = rx_idle_r[pos[1].ch][~pos[1].bt];
  end

  // Checksum of the difference between outgoing and incoming bits
  always_comb
  begin
    logic dif;
    dif = c_pos ? 1'b0 : (tx_bit ^ dt_s_r[0]);
    acc_nxt = {acc_r[2:0], 1'b0} ^ ({4{acc_r[3] ^ dif}} & fcs_pkg::CRC4_POLY);
  end

  // Difference checksum per sub-multiframe, applied in the next one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_r <= 4'h0;
      adj_r <= 4'h0;
    end
    else if (!recalc)
    begin
      acc_r <= 4'h0;
      adj_r <= 4'h0;
    end
    else if (edge_w[0])
    begin
      if (smf_end)
      begin
        adj_r <= acc_nxt;
        acc_r <= 4'h0;
      end
      else
        acc_r <= acc_nxt;
    end
  end

  // Loop code pattern index
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pidx_r <= 4'h0;
    else if (!loop_on)
      pidx_r <= 4'h0;
    else if (edge_w[0])
      pidx_r <= (pidx_r >= plast) ? 4'h0 : pidx_r + 4'h1;
  end

  // Serial outputs change on link clock edges
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_line_data <= 1'b0;
      rx_serial_data <= 1'b0;
    end
    else
    begin
      if (edge_w[0])
        tx_line_data <= tx_bit;
      if (edge_w[1])
        rx_serial_data <= rx_bit;
    end
  end

  // APB address decode and read mux
  assign idx = paddr[11:2];
  assign wr_en = psel && penable && pready && pwrite && !pslverr;
  always_comb
  begin
    rd_byte = 8'h00;
    rd_err = 1'b0;
    if (idx[9:5] == fcs_pkg::IDX_TX_IDLE[9:5])
      rd_byte = tx_idle_r[idx[4:0]];
    else if (idx[9:5] == fcs_pkg::IDX_RX_IDLE[9:5])
      rd_byte = rx_idle_r[idx[4:0]];
    else if (idx[9:2] == fcs_pkg::IDX_TX_IDLE_EN[9:2])
      rd_byte = tx_ie_r[{idx[1:0], 3'h0} +: 8];
    else if (idx[9:2] == fcs_pkg::IDX_RX_IDLE_EN[9:2])
      rd_byte = rx_ie_r[{idx[1:0], 3'h0} +: 8];
    else if (idx[9:2] == fcs_pkg::IDX_LOOPBACK[9:2])
      rd_byte = lb_r[{idx[1:0], 3'h0} +: 8];
    else
    begin
      case (idx)
        fcs_pkg::IDX_RX_MON_SEL: rd_byte = rx_sel_r;
        fcs_pkg::IDX_RX_MON_DATA: rd_byte = mon_r[1];
        fcs_pkg::IDX_TX_CTRL3: rd_byte = ctl3_r;
        fcs_pkg::IDX_TX_CTRL4: rd_byte = ctl4_r;
        fcs_pkg::IDX_TX_MON_SEL: rd_byte = tx_sel_r;
        fcs_pkg::IDX_TX_PAT1: rd_byte = pat1_r;
        fcs_pkg::IDX_TX_PAT2: rd_byte = pat2_r;
        fcs_pkg::IDX_TX_MON_DATA: rd_byte = mon_r[0];
        fcs_pkg::IDX_TX_CTRL1: rd_byte = ctl1_r;
        fcs_pkg::IDX_MODE: rd_byte = mode_r;
        fcs_pkg::IDX_SA: rd_byte = sa_r;
        default: rd_err = 1'b1;
      endcase
    end
  end

  // APB answer one cycle after setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (rd_err || paddr[31:12] != 20'h0);
      if (psel && !penable && !pwrite)
        prdata <= {24'h0, rd_byte};
    end
  end

  // Register writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 32; i++)
      begin
        tx_idle_r[i] <= fcs_pkg::RST_BYTE;
        rx_idle_r[i] <= fcs_pkg::RST_BYTE;
      end
      tx_ie_r <= 32'h0;
      rx_ie_r <= 32'h0;
      lb_r <= 32'h0;
      tx_sel_r <= fcs_pkg::RST_BYTE;
      rx_sel_r <= fcs_pkg::RST_BYTE;
      ctl1_r <= fcs_pkg::RST_BYTE;
      ctl3_r <= fcs_pkg::RST_BYTE;
      ctl4_r <= fcs_pkg::RST_BYTE;
      pat1_r <= fcs_pkg::RST_BYTE;
      pat2_r <= fcs_pkg::RST_BYTE;
      mode_r <= fcs_pkg::RST_BYTE;
      sa_r <= fcs_pkg::RST_BYTE;
    end
    else if (wr_en)
    begin
      if (idx[9:5] == fcs_pkg::IDX_TX_IDLE[9:5])
        tx_idle_r[idx[4:0]] <= pwdata[7:0];
      else if (idx[9:5] == fcs_pkg::IDX_RX_IDLE[9:5])
        rx_idle_r[idx[4:0]] <= pwdata[7:0];
      else if (idx[9:2] == fcs_pkg::IDX_TX_IDLE_EN[9:2])
        tx_ie_r[{idx[1:0], 3'h0} +: 8] <= pwdata[7:0];
      else if (idx[9:2] == fcs_pkg::IDX_RX_IDLE_EN[9:2])
        rx_ie_r[{idx[1:0], 3'h0} +: 8] <= pwdata[7:0];
      else if (idx[9:2] == fcs_pkg::IDX_LOOPBACK[9:2])
        lb_r[{idx[1:0], 3'h0} +: 8] <= pwdata[7:0];
      else
      begin
        case (idx)
          fcs_pkg::IDX_RX_MON_SEL: rx_sel_r <= pwdata[7:0];
          fcs_pkg::IDX_TX_CTRL3: ctl3_r <= pwdata[7:0];
          fcs_pkg::IDX_TX_CTRL4: ctl4_r <= pwdata[7:0];
          fcs_pkg::IDX_TX_MON_SEL: tx_sel_r <= pwdata[7:0];
          fcs_pkg::IDX_TX_PAT1: pat1_r <= pwdata[7:0];
          fcs_pkg::IDX_TX_PAT2: pat2_r <= pwdata[7:0];
          fcs_pkg::IDX_TX_CTRL1: ctl1_r <= pwdata[7:0];
          fcs_pkg::IDX_MODE: mode_r <= pwdata[7:0];
          fcs_pkg::IDX_SA: sa_r <= pwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  // Checks on monitors, substitution, pattern and checksum
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_tx_mon;
    edge_w[0] && !pos[0].fbit && pos[0].bt == 3'h7 && pos[0].ch == sel[0]
      |=> mon_r[0] == {$past(sh_r[0][6:0]), $past(tx_bit)};
  endproperty
  a_tx_mon: assert property (p_tx_mon) else $error("tx monitor byte wrong");

  property p_rx_mon;
    edge_w[1] && !pos[1].fbit && pos[1].bt == 3'h7 && pos[1].ch == sel[1]
      |=> mon_r[1] == {$past(sh_r[1][6:0]), $past(rx_bit)};
  endproperty
  a_rx_mon: assert property (p_rx_mon) else $error("rx monitor byte wrong");

  property p_t1_ch;
    edge_w[0] && !e1 |-> pos[0].ch <= fcs_pkg::T1_LAST_CH;
  endproperty
  a_t1_ch: assert property (p_t1_ch) else $error("T1 channel out of range");

  property p_tx_idle;
    edge_w[0] && !pos[0].fbit && tx_ie_r[pos[0].ch] && !loop_on && !recalc
      |=> tx_line_data == $past(tx_idle_r[pos[0].ch][~pos[0].bt]);
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("tx idle byte not sent");

  property p_rx_idle;
    edge_w[1] && !pos[1].fbit && rx_ie_r[pos[1].ch]
      |=> rx_serial_data == $past(rx_idle_r[pos[1].ch][~pos[1].bt]);
  endproperty
  a_rx_idle: assert property (p_rx_idle) else $error("rx idle byte not sent");

  property p_loopback;
    edge_w[0] && !pos[0].fbit && lb_r[pos[0].ch] && !tx_ie_r[pos[0].ch] && !loop_on
      && !recalc |=> tx_line_data == $past(dt_s_r[1]);
  endproperty
  a_loopback: assert property (p_loopback) else $error("loopback data missing");

  property p_loop_code;
    edge_w[0] && loop_on && !pos[0].fbit |=> tx_line_data == $past(patbit);
  endproperty
  a_loop_code: assert property (p_loop_code) else $error("loop code bit wrong");

  property p_fbit;
    edge_w[0] && loop_on && pos[0].fbit && !nofbit |=> tx_line_data == $past(dt_s_r[0]);
  endproperty
  a_fbit: assert property (p_fbit) else $error("framing bit not kept");

  property p_wrap;
    edge_w[0] && loop_on && pidx_r == plast |=> pidx_r == 4'h0 || !loop_on;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pattern does not repeat");

  property p_cbit;
    edge_w[0] && recalc && c_pos |=> tx_line_data == ($past(dt_s_r[0]) ^ $past(adj_r[~frm[2:1]]));
  endproperty
  a_cbit: assert property (p_cbit) else $error("checksum bit not adjusted");
endmodule

// ---- verification/fcs_backplane_model.sv ----
// Backplane and line stand-in: bit clock, frame syncs and channel bytes
`timescale 1ns/1ps
module fcs_backplane_model (
  // Set-up from the bench
  input wire logic e1,
  input wire logic [7:0] tx_seed,
  input wire logic [7:0] rx_seed,
  // Link signals
  output logic tx_backplane_clock,
  output logic tx_frame_sync,
  output logic tx_serial_data,
  output logic rx_backplane_clock,
  output logic rx_frame_sync,
  output logic rx_line_data,
  // Bit position for the bench
  output logic [7:0] bit_idx
);
  logic [3:0] frame_r;
  logic [7:0] c;

  // Channel bytes go out top bit first
  function automatic logic pick(input logic [7:0] b, input logic [2:0] k);
    return b[3'h7 - k];
  endfunction

  // Free running 80 ns bit clock, phase unrelated to pclk
  initial
  begin
    tx_backplane_clock = 1'b0;
    bit_idx = 8'h00;
    frame_r = 4'h0;
    tx_frame_sync = 1'b1;
    tx_serial_data = 1'b1;
    rx_line_data = 1'b1;
    #3.3;
    forever #40 tx_backplane_clock = ~tx_backplane_clock;
  end

  // Receive timing tied to transmit timing
  assign rx_backplane_clock = tx_backplane_clock;
  assign rx_frame_sync = tx_frame_sync;

  // Next bit launched on the falling edge so it is stable at the rising edge
  always @(negedge tx_backplane_clock)
  begin
    if (bit_idx == (e1 ? 8'hff : 8'hc0))
    begin
      bit_idx = 8'h00;
      frame_r = frame_r + 4'h1;
    end
    else
      bit_idx = bit_idx + 8'h01;
    c = e1 ? bit_idx : bit_idx - 8'h01;
    tx_frame_sync = (bit_idx == 8'h00) && (!e1 || frame_r == 4'h0);
    tx_serial_data = (!e1 && bit_idx == 8'h00) || pick({3'h0, c[7:3]} ^ tx_seed, c[2:0]);
    rx_line_data = pick({3'h0, c[7:3]} ^ rx_seed, c[2:0]);
  end
endmodule

// ---- verification/fcs_top_tb.sv ----
// Self-checking bench of the framer channel services block
`timescale 1ns/1ps
module fcs_top_tb;
  localparam int LIMIT = 90000;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, tx_line_data, rx_serial_data;
  logic tx_backplane_clock, tx_frame_sync, tx_serial_data;
  logic rx_backplane_clock, rx_frame_sync, rx_line_data;
  logic [7:0] bit_idx, cidx;
  logic [7:0] last_cap = 8'h00;
  logic e1m = 1'b0;
  logic [7:0] txs, rxs;
  logic txb [0:255];
  logic rxb [0:255];
  logic [31:0] rs = 32'd37;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;

  fcs_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .tx_backplane_clock, .tx_frame_sync, .tx_serial_data, .rx_backplane_clock,
    .rx_frame_sync, .rx_line_data, .tx_line_data, .rx_serial_data);
  fcs_backplane_model partner (.e1(e1m), .tx_seed(txs), .rx_seed(rxs), .tx_backplane_clock,
    .tx_frame_sync, .tx_serial_data, .rx_backplane_clock, .rx_frame_sync, .rx_line_data,
    .bit_idx);

  // System clock
  always #5 pclk = ~pclk;

  // Cycle ceiling against a hung run
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      failures++;
      end_sim();
    end
  end

  // Capture both serial outputs once they have settled for each bit
  always @(posedge tx_backplane_clock)
  begin
    cidx = bit_idx;
    repeat (6) @(posedge pclk);
    txb[cidx] = tx_line_data;
    rxb[cidx] = rx_serial_data;
    last_cap = cidx;
  end

  function automatic logic [7:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
  endfunction

  // Byte of one channel from the last captured frame
  function automatic logic [7:0] grab(input logic tx, input logic [4:0] ch);
    logic [7:0] b;
    int p;
    p = (e1m ? 0 : 1) + 8 * ch;
    for (int k = 0; k < 8; k++)
      b[7 - k] = tx ? txb[p + k] : rxb[p + k];
    return b;
  endfunction

  task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", s, exp, seen);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
    output logic [7:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {20'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n == 20)
      failures++;
  endtask

  task automatic wr(input logic [9:0] i, input logic [7:0] v);
    logic [7:0] d;
    logic e;
    apb(1'b1, i, v, d, e);
  endtask

  task automatic rdc(input string s, input logic [9:0] i, input logic [7:0] v);
    logic [7:0] d;
    logic e;
    apb(1'b0, i, 8'h00, d, e);
    check(s, d, v);
  endtask

  // Wait until whole frames have been captured
  task automatic frames(input int n);
    repeat (n)
    begin
      do @(posedge pclk); while (last_cap == (e1m ? 8'hff : 8'hc0));
      do @(posedge pclk); while (last_cap != (e1m ? 8'hff : 8'hc0));
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    logic [9:0] regs [4];
    logic [7:0] d, p1, p2, md, tc, rc, ic, ir;
    logic [1:0] ln;
    logic e;
    int m, ones, per;
    regs = '{fcs_pkg::IDX_TX_MON_SEL, fcs_pkg::IDX_RX_MON_SEL, fcs_pkg::IDX_TX_PAT1,
      fcs_pkg::IDX_TX_PAT2};
    txs = rnd();
    rxs = rnd();
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, write and read back, refused index
    foreach (regs[i])
    begin
      d = rnd() & 8'h1f;
      rdc("reset value", regs[i], fcs_pkg::RST_BYTE);
      wr(regs[i], d);
      rdc("read back", regs[i], d);
    end
    apb(1'b1, 10'h300, 8'h5a, d, e);
    check("error flag", e, 1'b1);
    apb(1'b0, 10'h300, 8'h00, d, e);
    check("refused data", d, 8'h00);
    $display("test registers done");
    // Monitors and idle codes on first, last and random channels
    for (int k = 0; k < 3; k++)
    begin
      tc = (k == 0) ? 8'h00 : (k == 1) ? 8'h17 : rnd() % 8'd24;
      rc = (k == 1) ? 8'h00 : (k == 0) ? 8'h17 : rnd() % 8'd24;
      wr(fcs_pkg::IDX_TX_MON_SEL, tc);
      wr(fcs_pkg::IDX_RX_MON_SEL, rc);
      frames(2);
      rdc("tx monitor", fcs_pkg::IDX_TX_MON_DATA, tc ^ txs);
      rdc("rx monitor", fcs_pkg::IDX_RX_MON_DATA, rc ^ rxs);
      ic = rnd();
      ir = rnd();
      wr(fcs_pkg::IDX_TX_IDLE + {2'h0, tc}, ic);
      wr(fcs_pkg::IDX_RX_IDLE + {2'h0, rc}, ir);
      wr(fcs_pkg::IDX_TX_IDLE_EN + {8'h0, tc[4:3]}, 8'h01 << tc[2:0]);
      wr(fcs_pkg::IDX_RX_IDLE_EN + {8'h0, rc[4:3]}, 8'h01 << rc[2:0]);
      frames(2);
      check("tx idle", grab(1'b1, tc[4:0]), ic);
      check("tx other", grab(1'b1, tc[4:0] ^ 5'h01), (tc ^ 8'h01) ^ txs);
      check("rx idle", grab(1'b0, rc[4:0]), ir);
      rdc("tx idle monitor", fcs_pkg::IDX_TX_MON_DATA, ic);
      rdc("rx idle monitor", fcs_pkg::IDX_RX_MON_DATA, ir);
      wr(fcs_pkg::IDX_TX_IDLE_EN + {8'h0, tc[4:3]}, 8'h00);
      wr(fcs_pkg::IDX_RX_IDLE_EN + {8'h0, rc[4:3]}, 8'h00);
    end
    $display("test monitors and idle codes done");
    // Two channels looped at once
    wr(fcs_pkg::IDX_LOOPBACK, 8'h01);
    wr(fcs_pkg::IDX_LOOPBACK + 10'h002, 8'h80);
    wr(fcs_pkg::IDX_TX_MON_SEL, 8'h17);
    frames(2);
    check("loop first", grab(1'b1, 5'h00), rxs);
    check("loop last", grab(1'b1, 5'h17), 8'h17 ^ rxs);
    check("not looped", grab(1'b1, 5'h01), 8'h01 ^ txs);
    rdc("loop monitor", fcs_pkg::IDX_TX_MON_DATA, 8'h17 ^ rxs);
    wr(fcs_pkg::IDX_LOOPBACK, 8'h00);
    wr(fcs_pkg::IDX_LOOPBACK + 10'h002, 8'h00);
    $display("test loopback done");
    // Loop codes: 5 bits from 80h, 16 bits random, 7 bits without framing bit
    for (int t = 0; t < 3; t++)
    begin
      p1 = (t == 0) ? 8'h80 : rnd();
      p2 = rnd();
      ln = (t == 1) ? 2'h3 : (t == 2) ? 2'h2 : 2'h0;
      md = (t == 2) ? 8'h02 : 8'h00;
      per = (ln == 2'h3) ? 16 : 5 + ln;
      wr(fcs_pkg::IDX_TX_PAT1, p1);
      wr(fcs_pkg::IDX_TX_PAT2, p2);
      wr(fcs_pkg::IDX_TX_CTRL4, {6'h0, ln});
      wr(fcs_pkg::IDX_MODE, md);
      wr(fcs_pkg::IDX_TX_CTRL3, 8'h01);
      frames(2);
      m = 0;
      ones = 0;
      for (int n = (md[1] ? per : per + 1); n < 193; n++)
        m += (txb[n] !== txb[n - per]);
      for (int n = 1; n <= per; n++)
        ones += (txb[n] === 1'b1);
      check("code period", m, 0);
      check("code ones", ones, (ln == 2'h3) ? $countones({p1, p2}) : $countones(p1 >> (8 - per)));
      if (!md[1])
        check("framing bit", txb[0], 1'b1);
    end
    wr(fcs_pkg::IDX_TX_CTRL3, 8'h00);
    wr(fcs_pkg::IDX_MODE, 8'h00);
    frames(2);
    check("code off", grab(1'b1, 5'h05), 8'h05 ^ txs);
    $display("test loop code done");
    // E1: last channel monitors and untouched time slot 0
    wr(fcs_pkg::IDX_MODE, 8'h01);
    e1m = 1'b1;
    wr(fcs_pkg::IDX_TX_MON_SEL, 8'h1f);
    wr(fcs_pkg::IDX_RX_MON_SEL, 8'h1f);
    wr(fcs_pkg::IDX_TX_CTRL3, 8'h01);
    for (int k = 0; k < 2; k++)
    begin
      wr(fcs_pkg::IDX_TX_CTRL1, k[7:0]);
      frames(3);
      check("slot zero", grab(1'b1, 5'h00), txs);
    end
    rdc("e1 rx monitor", fcs_pkg::IDX_RX_MON_DATA, 8'h1f ^ rxs);
    rdc("e1 tx monitor", fcs_pkg::IDX_TX_MON_DATA, 8'h1f ^ txs);
    $display("test e1 done");
    end_sim();
  end
endmodule
